//--- rtl/cds_carrier_divider_sets.sv
// APB register bank holding two synthesizer counter sets and their selector
//
// Overview of operation
// - Read/write 8-bit first-set reference count at index 0x06, reset 0x77.
// - Read/write 8-bit first-set P count at index 0x07, reset 0x64.
// - Read/write 8-bit first-set S count at index 0x08, reset 0x32.
// - Read/write 8-bit second-set reference count at index 0x09, reset 0x74.
// - Read/write 8-bit second-set P count at index 0x0A, reset 0x62.
// - Read/write 8-bit second-set S count at index 0x0B, reset 0x32.
// - Select bit zero feeds the first set to the synthesizer.
// - Select bit one feeds the second set to the synthesizer.
// - First set at reset values gives the 915 MHz carrier.
// - Second set at reset values gives the 920 MHz carrier.
`timescale 1ns/1ps
module cds_carrier_divider_sets (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cds_pkg::CDS_ADDR_W-1:0] paddr,
    input wire logic [cds_pkg::CDS_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [cds_pkg::CDS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [cds_pkg::CDS_REG_W-1:0] synthRef,
    output logic [cds_pkg::CDS_REG_W-1:0] synthP,
    output logic [cds_pkg::CDS_REG_W-1:0] synthS,
    output logic synthSet,
    output logic synthLoad
);

    typedef struct packed {
        logic [cds_pkg::CDS_REG_W-1:0] set1Ref;
        logic [cds_pkg::CDS_REG_W-1:0] set1P;
        logic [cds_pkg::CDS_REG_W-1:0] set1S;
        logic [cds_pkg::CDS_REG_W-1:0] set2Ref;
        logic [cds_pkg::CDS_REG_W-1:0] set2P;
        logic [cds_pkg::CDS_REG_W-1:0] set2S;
        logic freqSetSelect;
        logic updateHold;
        logic [cds_pkg::CDS_DATA_W-1:0] readData;
        logic slaveError;
    } cds_regs_t;

    cds_regs_t state;
    cds_regs_t next_state;

    // Bus phase decode
    logic setupPhase;
    logic accessPhase;
    logic writeTaken;
    logic lowLane;
    logic [cds_pkg::CDS_DATA_W-1:0] activeStatus;

    // Address match against a register index
    function automatic logic addr_is(
        input logic [cds_pkg::CDS_ADDR_W-1:0] addr,
        input logic [cds_pkg::CDS_IDX_W-1:0] idx
    );
        addr_is = (addr == cds_pkg::cds_byte_addr(idx));
    endfunction

    // True for any register software may write
    function automatic logic addr_writable(input logic [cds_pkg::CDS_ADDR_W-1:0] addr);
        addr_writable = addr_is(addr, cds_pkg::CDS_IDX_GEN_CONFIG)
            || addr_is(addr, cds_pkg::CDS_IDX_SET1_REF)
            || addr_is(addr, cds_pkg::CDS_IDX_SET1_P)
            || addr_is(addr, cds_pkg::CDS_IDX_SET1_S)
            || addr_is(addr, cds_pkg::CDS_IDX_SET2_REF)
            || addr_is(addr, cds_pkg::CDS_IDX_SET2_P)
            || addr_is(addr, cds_pkg::CDS_IDX_SET2_S);
    endfunction

    // Zero-extend an 8-bit register onto the data bus
    function automatic logic [cds_pkg::CDS_DATA_W-1:0] widen(input logic [cds_pkg::CDS_REG_W-1:0] val);
        widen = {{(cds_pkg::CDS_DATA_W - cds_pkg::CDS_REG_W){1'b0}}, val};
    endfunction

    // Zero-wait slave; answer stands in the first access cycle
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign lowLane = pstrb[0];
    assign writeTaken = accessPhase && pwrite && lowLane && addr_writable(paddr);
    assign pready = 1'b1;

    // Snapshot of what the synthesizer is running from
    always_comb begin
        activeStatus = '0;
        activeStatus[cds_pkg::CDS_ACT_S_LSB +: cds_pkg::CDS_REG_W] = synthS;
        activeStatus[cds_pkg::CDS_ACT_P_LSB +: cds_pkg::CDS_REG_W] = synthP;
        activeStatus[cds_pkg::CDS_ACT_REF_LSB +: cds_pkg::CDS_REG_W] = synthRef;
        activeStatus[cds_pkg::CDS_ACT_SEL_BIT] = synthSet;
    end

    // Next register contents, read data and error
    always_comb begin
        next_state = state;

        // Writes land on the access edge; pready is always high
        if (writeTaken) begin
            if (addr_is(paddr, cds_pkg::CDS_IDX_GEN_CONFIG)) begin
                next_state.freqSetSelect = pwdata[cds_pkg::CDS_SEL_BIT];
                next_state.updateHold = pwdata[cds_pkg::CDS_HOLD_BIT];
            end
            if (addr_is(paddr, cds_pkg::CDS_IDX_SET1_REF)) begin
                next_state.set1Ref = pwdata[cds_pkg::CDS_REG_W-1:0];
            end
            if (addr_is(paddr, cds_pkg::CDS_IDX_SET1_P)) begin
                next_state.set1P = pwdata[cds_pkg::CDS_REG_W-1:0];
            end
            if (addr_is(paddr, cds_pkg::CDS_IDX_SET1_S)) begin
                next_state.set1S = pwdata[cds_pkg::CDS_REG_W-1:0];
            end
            if (addr_is(paddr, cds_pkg::CDS_IDX_SET2_REF)) begin
                next_state.set2Ref = pwdata[cds_pkg::CDS_REG_W-1:0];
            end
            if (addr_is(paddr, cds_pkg::CDS_IDX_SET2_P)) begin
                next_state.set2P = pwdata[cds_pkg::CDS_REG_W-1:0];
            end
            if (addr_is(paddr, cds_pkg::CDS_IDX_SET2_S)) begin
                next_state.set2S = pwdata[cds_pkg::CDS_REG_W-1:0];
            end
        end

        // Read data and error are captured in the setup cycle
        if (setupPhase) begin
            next_state.readData = '0;
            next_state.slaveError = 1'b0;
            if (addr_is(paddr, cds_pkg::CDS_IDX_GEN_CONFIG)) begin
                next_state.readData[cds_pkg::CDS_SEL_BIT] = state.freqSetSelect;
                next_state.readData[cds_pkg::CDS_HOLD_BIT] = state.updateHold;
            end else if (addr_is(paddr, cds_pkg::CDS_IDX_SET1_REF)) begin
                next_state.readData = widen(state.set1Ref);
            end else if (addr_is(paddr, cds_pkg::CDS_IDX_SET1_P)) begin
                next_state.readData = widen(state.set1P);
            end else if (addr_is(paddr, cds_pkg::CDS_IDX_SET1_S)) begin
                next_state.readData = widen(state.set1S);
            end else if (addr_is(paddr, cds_pkg::CDS_IDX_SET2_REF)) begin
                next_state.readData = widen(state.set2Ref);
            end else if (addr_is(paddr, cds_pkg::CDS_IDX_SET2_P)) begin
                next_state.readData = widen(state.set2P);
            end else if (addr_is(paddr, cds_pkg::CDS_IDX_SET2_S)) begin
                next_state.readData = widen(state.set2S);
            end else if (addr_is(paddr, cds_pkg::CDS_IDX_ACTIVE)) begin
                next_state.readData = activeStatus;
                next_state.slaveError = pwrite; // Status is read-only
            end else begin
                next_state.slaveError = 1'b1; // Unmapped or misaligned
            end
            if (pwrite) begin
                next_state.readData = '0;
            end
        end
    end

    // Register the whole state; reset gives the documented values
    always_ff @(posedge mclk) begin
        if (reset) begin
            state.set1Ref <= cds_pkg::CDS_RST_SET1_REF;
            state.set1P <= cds_pkg::CDS_RST_SET1_P;
            state.set1S <= cds_pkg::CDS_RST_SET1_S;
            state.set2Ref <= cds_pkg::CDS_RST_SET2_REF;
            state.set2P <= cds_pkg::CDS_RST_SET2_P;
            state.set2S <= cds_pkg::CDS_RST_SET2_S;
            state.freqSetSelect <= cds_pkg::CDS_RST_SEL;
            state.updateHold <= cds_pkg::CDS_RST_HOLD;
            state.readData <= '0;
            state.slaveError <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Answer only in the access phase, so the bus sees no stale data
    assign prdata = accessPhase ? state.readData : '0;
    assign pslverr = accessPhase && state.slaveError;

    // Group selection towards the synthesizer
    cds_set_mux setMux (
        .mclk(mclk),
        .reset(reset),
        .freqSetSelect(state.freqSetSelect),
        .updateHold(state.updateHold),
        .set1Ref(state.set1Ref),
        .set1P(state.set1P),
        .set1S(state.set1S),
        .set2Ref(state.set2Ref),
        .set2P(state.set2P),
        .set2S(state.set2S),
        .synthRef(synthRef),
        .synthP(synthP),
        .synthS(synthS),
        .synthSet(synthSet),
        .synthLoad(synthLoad)
    );

endmodule

//--- inc/cds_pkg.sv
// Register map, reset values and field layout of the carrier divider sets
package cds_pkg;

    // Bus widths
    localparam int CDS_ADDR_W = 12;
    localparam int CDS_DATA_W = 32;
    localparam int CDS_REG_W = 8;
    localparam int CDS_IDX_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_GEN_CONFIG = 10'h000;
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_SET1_REF = 10'h006;
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_SET1_P = 10'h007;
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_SET1_S = 10'h008;
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_SET2_REF = 10'h009;
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_SET2_P = 10'h00A;
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_SET2_S = 10'h00B;
    localparam logic [CDS_IDX_W-1:0] CDS_IDX_ACTIVE = 10'h00F;

    // Reset values of the counter registers
    localparam logic [CDS_REG_W-1:0] CDS_RST_SET1_REF = 8'h77;
    localparam logic [CDS_REG_W-1:0] CDS_RST_SET1_P = 8'h64;
    localparam logic [CDS_REG_W-1:0] CDS_RST_SET1_S = 8'h32;
    localparam logic [CDS_REG_W-1:0] CDS_RST_SET2_REF = 8'h74;
    localparam logic [CDS_REG_W-1:0] CDS_RST_SET2_P = 8'h62;
    localparam logic [CDS_REG_W-1:0] CDS_RST_SET2_S = 8'h32;

    // General configuration fields
    localparam int CDS_SEL_BIT = 0;
    localparam int CDS_HOLD_BIT = 1;
    localparam logic CDS_RST_SEL = 1'h0;
    localparam logic CDS_RST_HOLD = 1'h0;

    // Active set status layout
    localparam int CDS_ACT_S_LSB = 0;
    localparam int CDS_ACT_P_LSB = 8;
    localparam int CDS_ACT_REF_LSB = 16;
    localparam int CDS_ACT_SEL_BIT = 24;

    // Byte address of a register index
    function automatic logic [CDS_ADDR_W-1:0] cds_byte_addr(input logic [CDS_IDX_W-1:0] idx);
        cds_byte_addr = {idx, 2'h0};
    endfunction

endpackage

//--- rtl/cds_set_mux.sv
// Selects one counter set and presents it to the synthesizer as a group
`timescale 1ns/1ps
module cds_set_mux (
    input wire logic mclk,
    input wire logic reset,
    input wire logic freqSetSelect,
    input wire logic updateHold,
    input wire logic [cds_pkg::CDS_REG_W-1:0] set1Ref,
    input wire logic [cds_pkg::CDS_REG_W-1:0] set1P,
    input wire logic [cds_pkg::CDS_REG_W-1:0] set1S,
    input wire logic [cds_pkg::CDS_REG_W-1:0] set2Ref,
    input wire logic [cds_pkg::CDS_REG_W-1:0] set2P,
    input wire logic [cds_pkg::CDS_REG_W-1:0] set2S,
    output logic [cds_pkg::CDS_REG_W-1:0] synthRef,
    output logic [cds_pkg::CDS_REG_W-1:0] synthP,
    output logic [cds_pkg::CDS_REG_W-1:0] synthS,
    output logic synthSet,
    output logic synthLoad
);

    typedef struct packed {
        logic [cds_pkg::CDS_REG_W-1:0] refCount;
        logic [cds_pkg::CDS_REG_W-1:0] p;
        logic [cds_pkg::CDS_REG_W-1:0] s;
        logic sel;
        logic load;
    } cds_mux_t;

    cds_mux_t state;
    cds_mux_t next_state;

    // All three values switch on one edge; hold freezes the group
    always_comb begin
        next_state = state;
        next_state.load = 1'b0;
        if (!updateHold) begin
            next_state.sel = freqSetSelect;
            if (freqSetSelect) begin
                next_state.refCount = set2Ref;
                next_state.p = set2P;
                next_state.s = set2S;
            end else begin
                next_state.refCount = set1Ref;
                next_state.p = set1P;
                next_state.s = set1S;
            end
            next_state.load = (next_state.refCount != state.refCount) || (next_state.p != state.p)
                || (next_state.s != state.s) || (next_state.sel != state.sel);
        end
    end

    // Reset presents the first set's reset values
    always_ff @(posedge mclk) begin
        if (reset) begin
            state.refCount <= cds_pkg::CDS_RST_SET1_REF;
            state.p <= cds_pkg::CDS_RST_SET1_P;
            state.s <= cds_pkg::CDS_RST_SET1_S;
            state.sel <= cds_pkg::CDS_RST_SEL;
            state.load <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign synthRef = state.refCount;
    assign synthP = state.p;
    assign synthS = state.s;
    assign synthSet = state.sel;
    assign synthLoad = state.load;

endmodule

//--- test/cds_carrier_divider_sets_assertions.sv
// Port-level checks for the carrier divider set bank
`timescale 1ns/1ps
module cds_carrier_divider_sets_assertions (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cds_pkg::CDS_ADDR_W-1:0] paddr,
    input wire logic [cds_pkg::CDS_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [cds_pkg::CDS_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [cds_pkg::CDS_REG_W-1:0] synthRef,
    input wire logic [cds_pkg::CDS_REG_W-1:0] synthP,
    input wire logic [cds_pkg::CDS_REG_W-1:0] synthS,
    input wire logic synthSet,
    input wire logic synthLoad
);
    logic acc;
    logic mapped;
    logic selBit;
    logic holdBit;
    logic [9:0] idx;
    // Access phase and address decode
    assign acc = psel && penable;
    assign idx = paddr[11:2];
    assign mapped = paddr[1:0] == 2'h0 && (idx == 10'h000 || idx == 10'h00F || (idx >= 10'h006 && idx <= 10'h00B));
    // Mirror of the select and hold bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            selBit <= 1'h0;
            holdBit <= 1'h0;
        end else if (acc && pwrite && pstrb[0] && paddr == 12'h000) begin
            selBit <= pwdata[0];
            holdBit <= pwdata[1];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    chk_reset_values: assert property ($fell(reset) |-> synthRef == 8'h77 && synthP == 8'h64 && synthS == 8'h32 && !synthSet)
        else $error("synth outputs not at first set defaults");
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_idle_quiet: assert property (!acc |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside access");
    chk_err_decode: assert property (acc |-> pslverr == (!mapped || (pwrite && idx == 10'h00F)))
        else $error("error flag does not match address");
    chk_read_upper: assert property (acc && !pwrite && mapped && idx != 10'h00F |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_write_reach: assert property (acc && pwrite && pstrb[0] && paddr == 12'h018 && !selBit && !holdBit
        |-> ##2 synthRef == $past(pwdata[7:0], 2))
        else $error("selected reference count not forwarded");
    chk_unsel_quiet: assert property (acc && pwrite && idx >= 10'h009 && idx <= 10'h00B && !selBit
        |-> ##2 $stable({synthRef, synthP, synthS}))
        else $error("unselected set disturbed synth outputs");
    chk_set_follows: assert property (acc && pwrite && pstrb[0] && paddr == 12'h000 && !pwdata[1]
        |-> ##2 synthSet == $past(pwdata[0], 2))
        else $error("active set does not follow select");
    chk_load_change: assert property ($changed({synthRef, synthP, synthS, synthSet}) |-> synthLoad)
        else $error("no load pulse on change");
    cover property (acc && pwrite && paddr == 12'h018);
    cover property ($rose(synthSet));
    cover property (acc && pslverr);
endmodule
bind cds_carrier_divider_sets cds_carrier_divider_sets_assertions chkU (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .synthRef(synthRef), .synthP(synthP), .synthS(synthS),
    .synthSet(synthSet), .synthLoad(synthLoad));

//--- test/tb_cds_carrier_divider_sets.sv
// Self-checking bench for the carrier divider set bank
`timescale 1ns/1ps
module tb_cds_carrier_divider_sets;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, synthSet, synthLoad, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] synthRef, synthP, synthS;
    logic [7:0] cur [6] = '{8'h77, 8'h64, 8'h32, 8'h74, 8'h62, 8'h32};
    int miscompares = 0;
    int samplesChecked = 0;
    cds_carrier_divider_sets dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .synthRef(synthRef), .synthP(synthP), .synthS(synthS), .synthSet(synthSet), .synthLoad(synthLoad));
    // Clock at 50 MHz
    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end
    task automatic summarize;
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, waiting for pready with no bound and checking that the access takes one cycle
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
        int n;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1);
        chk("access cycles", 32'h1, n);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [11:0] ba(input int i);
        return 12'(24 + 4 * i);
    endfunction
    // Waits for a change to reach the synth outputs, then checks them
    task automatic settle(input logic set, input logic load);
        @(posedge mclk);
        @(negedge mclk);
        chk("synthLoad", {31'h0, load}, {31'h0, synthLoad});
        if (set) begin
            chk("synth set2", {1'h1, cur[3], cur[4], cur[5]}, {synthSet, synthRef, synthP, synthS});
        end else begin
            chk("synth set1", {1'h0, cur[0], cur[1], cur[2]}, {synthSet, synthRef, synthP, synthS});
        end
    endtask
    task automatic testReset;
        chk("synth reset", {1'h0, 24'h776432}, {synthSet, synthRef, synthP, synthS});
        for (int i = 0; i < 6; i++) begin
            xfer(1'h0, ba(i), 32'h0, 4'h0);
            chk("reset value", {24'h0, cur[i]}, rd);
        end
    endtask
    task automatic testReadWrite;
        for (int i = 0; i < 6; i++) begin
            cur[i] = 8'hA5 ^ 8'(i * 17);
            xfer(1'h1, ba(i), {24'hFFFFFF, cur[i]}, 4'hF);
            xfer(1'h1, ba(i), 32'h0, 4'h0);
            xfer(1'h0, ba(i), 32'h0, 4'h0);
            chk("readback", {24'h0, cur[i]}, rd);
        end
        settle(1'h0, 1'h0);
    endtask
    task automatic testSelect;
        xfer(1'h1, 12'h000, 32'h1, 4'h1);
        settle(1'h1, 1'h1);
        xfer(1'h0, 12'h03C, 32'h0, 4'h0);
        chk("active status", {7'h0, 1'h1, cur[3], cur[4], cur[5]}, rd);
        cur[5] = 8'h3C;
        xfer(1'h1, ba(5), 32'h3C, 4'h1);
        settle(1'h1, 1'h1);
        cur[0] = 8'hC3;
        xfer(1'h1, ba(0), 32'hC3, 4'h1);
        settle(1'h1, 1'h0);
        xfer(1'h0, ba(0), 32'h0, 4'h0);
        chk("unselected rw", 32'hC3, rd);
        xfer(1'h1, 12'h000, 32'h0, 4'h1);
        settle(1'h0, 1'h1);
    endtask
    task automatic testErrors;
        xfer(1'h0, 12'h040, 32'h0, 4'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        xfer(1'h0, 12'h019, 32'h0, 4'h0);
        chk("misaligned err", 32'h1, {31'h0, er});
        xfer(1'h1, 12'h03C, 32'hFF, 4'hF);
        chk("status write err", 32'h1, {31'h0, er});
        xfer(1'h0, ba(3), 32'h0, 4'h0);
        chk("mapped no err", {31'h0, 1'h0}, {31'h0, er});
    endtask
    // Hold freezes the synth group, then a mid-run reset restores defaults
    task automatic testHold;
        xfer(1'h1, 12'h000, 32'h2, 4'h1);
        xfer(1'h0, 12'h000, 32'h0, 4'h0);
        chk("config readback", 32'h2, rd);
        xfer(1'h1, ba(1), 32'h5A, 4'h1);
        settle(1'h0, 1'h0);
        xfer(1'h0, ba(1), 32'h0, 4'h0);
        chk("held set rw", 32'h5A, rd);
        cur[1] = 8'h5A;
        xfer(1'h1, 12'h000, 32'h0, 4'h1);
        settle(1'h0, 1'h1);
        @(posedge mclk);
        reset <= 1'h1;
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        @(negedge mclk);
        chk("synth re-reset", {1'h0, 24'h776432}, {synthSet, synthRef, synthP, synthS});
        xfer(1'h0, ba(1), 32'h0, 4'h0);
        chk("re-reset value", 32'h64, rd);
    endtask
    // Watchdog
    initial begin
        #200us;
        miscompares++;
        summarize();
    end
    initial begin
        reset = 1'h1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (12) @(posedge mclk);
        reset <= 1'h0;
        @(negedge mclk);
        testReset();
        testReadWrite();
        testSelect();
        testErrors();
        testHold();
        summarize();
    end
endmodule
